// ===== shared/adc_port_regs.svh
// register map, field layout and timing constants of the converter output port
`ifndef ADC_PORT_REGS_SVH
`define ADC_PORT_REGS_SVH

`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_IRQ_CLR 4'h2
`define REG_IRQ_EN 4'h3
`define REG_SAMPLE_A 4'h4
`define REG_SAMPLE_B 4'h5
`define REG_COUNT 4'h6

`define CTRL_SWAP_BIT 0
`define CTRL_PD_A_BIT 1
`define CTRL_OEN_A_BIT 2
`define CTRL_PD_B_BIT 3
`define CTRL_OEN_B_BIT 4
`define CTRL_FMT_LSB 5
`define CTRL_RESET 32'h0000_0015

`define EVT_OVR_A 0
`define EVT_OVR_B 1
`define EVT_SAMPLE_B 2
`define EVT_COUNT 3

`define PIPE_LATENCY 5
`define RESULT_MSB 9

`endif

// ===== shared/adc_port_pkg.sv
// types shared by the converter output port
package adc_port_pkg;
    typedef enum logic [1:0] {
        FMT_OB_DCS_OFF,
        FMT_OB_DCS_ON,
        FMT_TC_DCS_ON,
        FMT_TC_DCS_OFF
    } format_sel_t;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_HIZ,
        MODE_NAP,
        MODE_SLEEP
    } chan_mode_t;

    typedef struct packed {
        logic ovr;
        logic [9:0] code;
    } sample_t;

    typedef struct packed {
        logic [9:0] data;
        logic [9:0] oen_n;
    } result_bus_t;
endpackage

// ===== core/adc_chan_pipe.sv
// per-channel sample edge detect, mode decode and five-stage result pipeline
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_regs.svh"
module adc_chan_pipe (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // sample clock pin and digitized input
    input wire logic sample_clock_i,
    input wire adc_port_pkg::sample_t analog_i,
    // mode controls
    input wire logic power_down_i,
    input wire logic output_enable_n_i,
    input wire logic twos_comp_i,
    // results
    output logic take_o,
    output adc_port_pkg::chan_mode_t mode_o,
    output adc_port_pkg::sample_t result_o
);
    import adc_port_pkg::*;

    logic s1_q, s2_q, s3_q;
    sample_t pipe_q [`PIPE_LATENCY];
    sample_t ana1_q, ana2_q;
    chan_mode_t mode_d;

    // two flops before use, third for edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= sample_clock_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // result bits are held steady around each sample edge, and the edge is
    // seen two clocks late, so a plain two-stage copy is safe here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ana1_q <= '0;
            ana2_q <= '0;
        end else begin
            ana1_q <= analog_i;
            ana2_q <= ana1_q;
        end
    end

    always_comb begin
        case ({power_down_i, output_enable_n_i})
            2'b00: mode_d = MODE_NORMAL;
            2'b01: mode_d = MODE_HIZ;
            2'b10: mode_d = MODE_NAP;
            2'b11: mode_d = MODE_SLEEP;
            default: mode_d = MODE_SLEEP;
        endcase
    end

    assign mode_o = mode_d;
    // napping or sleeping channels take no samples
    assign take_o = s2_q && !s3_q && !power_down_i;

    genvar g;
    generate
        for (g = 0; g < `PIPE_LATENCY; g++) begin : g_stage
            if (g == 0) begin : g_load
                always_ff @(posedge clk_i) begin
                    if (rst_i) begin
                        pipe_q[g] <= '0;
                    end else if (take_o) begin
                        pipe_q[g].ovr <= ana2_q.ovr;
                        // two's complement is offset binary with msb flipped
                        pipe_q[g].code <= ana2_q.code ^ {twos_comp_i, 9'h000};
                    end
                end
            end else begin : g_shift
                always_ff @(posedge clk_i) begin
                    if (rst_i) begin
                        pipe_q[g] <= '0;
                    end else if (take_o) begin
                        pipe_q[g] <= pipe_q[g-1];
                    end
                end
            end
        end
    endgenerate

    assign result_o = pipe_q[`PIPE_LATENCY-1];
endmodule // adc_chan_pipe
`default_nettype wire

// ===== core/adc_port_top.sv
// dual converter output port: pin muxing, modes, format, overflow and wishbone registers
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_regs.svh"
module adc_port_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o,
    // converter pins
    input wire logic sample_clock_chan_a_i,
    input wire logic sample_clock_chan_b_i,
    input wire adc_port_pkg::sample_t analog_a_i,
    input wire adc_port_pkg::sample_t analog_b_i,
    // output port
    output adc_port_pkg::result_bus_t result_bus_a_o,
    output adc_port_pkg::result_bus_t result_bus_b_o,
    output logic data_ready_clock_o,
    output logic range_exceeded_flag_o,
    output logic stabilizer_on_o
);
    import adc_port_pkg::*;

    logic [31:0] ctrl_q;
    logic [`EVT_COUNT-1:0] status_q, status_d, irq_en_q, evt;
    logic [31:0] count_q;
    logic ack_q;
    logic take_a, take_b;
    chan_mode_t mode_a, mode_b;
    sample_t res_a, res_b;
    format_sel_t fmt;
    logic tc;
    logic [3:0] idx;
    logic wr, rd;
    logic [31:0] rdata_d;
    logic ckb1_q, ckb2_q;
    result_bus_t bus_a_d, bus_b_d;

    assign fmt = format_sel_t'(ctrl_q[`CTRL_FMT_LSB+1:`CTRL_FMT_LSB]);
    assign idx = adr_i[5:2];
    assign wr = cyc_i && stb_i && we_i && !ack_q;
    assign rd = cyc_i && stb_i && !we_i && !ack_q;

    always_comb begin
        case (fmt)
            FMT_OB_DCS_OFF: tc = 1'b0;
            FMT_OB_DCS_ON: tc = 1'b0;
            FMT_TC_DCS_ON: tc = 1'b1;
            FMT_TC_DCS_OFF: tc = 1'b1;
            default: tc = 1'b0;
        endcase
    end

    adc_chan_pipe u_chan_a (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sample_clock_i(sample_clock_chan_a_i),
        .analog_i(analog_a_i),
        .power_down_i(ctrl_q[`CTRL_PD_A_BIT]),
        .output_enable_n_i(ctrl_q[`CTRL_OEN_A_BIT]),
        .twos_comp_i(tc),
        .take_o(take_a),
        .mode_o(mode_a),
        .result_o(res_a)
    );

    adc_chan_pipe u_chan_b (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sample_clock_i(sample_clock_chan_b_i),
        .analog_i(analog_b_i),
        .power_down_i(ctrl_q[`CTRL_PD_B_BIT]),
        .output_enable_n_i(ctrl_q[`CTRL_OEN_B_BIT]),
        .twos_comp_i(tc),
        .take_o(take_b),
        .mode_o(mode_b),
        .result_o(res_b)
    );

    // bus routing; a bus drives only while its source channel is normal
    always_comb begin
        if (ctrl_q[`CTRL_SWAP_BIT]) begin
            bus_a_d.data = res_a.code;
            bus_b_d.data = res_b.code;
            bus_a_d.oen_n = {10{mode_a != MODE_NORMAL}};
            bus_b_d.oen_n = {10{mode_b != MODE_NORMAL}};
        end else begin
            bus_a_d.data = res_b.code;
            bus_b_d.data = res_a.code;
            bus_a_d.oen_n = {10{mode_b != MODE_NORMAL}};
            bus_b_d.oen_n = {10{mode_a != MODE_NORMAL}};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_bus_a_o <= '{data: 10'h000, oen_n: 10'h3FF};
            result_bus_b_o <= '{data: 10'h000, oen_n: 10'h3FF};
        end else begin
            result_bus_a_o <= bus_a_d;
            result_bus_b_o <= bus_b_d;
        end
    end

    // data-ready clock follows channel B's synchronised clock, so data is
    // settled by its falling edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ckb1_q <= 1'b0;
            ckb2_q <= 1'b0;
            data_ready_clock_o <= 1'b0;
        end else begin
            ckb1_q <= sample_clock_chan_b_i;
            ckb2_q <= ckb1_q;
            data_ready_clock_o <= ckb2_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            range_exceeded_flag_o <= 1'b0;
            stabilizer_on_o <= 1'b0;
        end else begin
            range_exceeded_flag_o <= res_a.ovr || res_b.ovr;
            stabilizer_on_o <= (fmt == FMT_OB_DCS_ON) || (fmt == FMT_TC_DCS_ON);
        end
    end

    // events: per-channel overflow leaving the pipe, and each channel B sample
    assign evt[`EVT_OVR_A] = take_a && res_a.ovr;
    assign evt[`EVT_OVR_B] = take_b && res_b.ovr;
    assign evt[`EVT_SAMPLE_B] = take_b;

    // set wins over a clear in the same cycle
    always_comb begin
        status_d = status_q;
        if (wr && idx == `REG_IRQ_CLR && sel_i[0]) begin
            status_d = status_q & ~dat_i[`EVT_COUNT-1:0];
        end
        status_d = status_d | evt;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_q <= '0;
            irq_o <= 1'b0;
        end else begin
            status_q <= status_d;
            irq_o <= |(status_d & irq_en_q);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= 32'h0000_0000;
        end else if (take_b) begin
            count_q <= count_q + 32'h0000_0001;
        end
    end

    // control writes honour byte lanes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `CTRL_RESET;
            irq_en_q <= '0;
        end else if (wr) begin
            if (idx == `REG_CTRL) begin
                for (int i = 0; i < 4; i++) begin
                    if (sel_i[i]) begin
                        ctrl_q[i*8 +: 8] <= dat_i[i*8 +: 8];
                    end
                end
            end
            if (idx == `REG_IRQ_EN && sel_i[0]) begin
                irq_en_q <= dat_i[`EVT_COUNT-1:0];
            end
        end
    end

    always_comb begin
        case (idx)
            `REG_CTRL: rdata_d = {25'h0, ctrl_q[6:0]};
            `REG_STATUS: rdata_d = {29'h0, status_q};
            `REG_IRQ_EN: rdata_d = {29'h0, irq_en_q};
            `REG_SAMPLE_A: rdata_d = {16'h0, 2'h0, mode_a, 1'b0, res_a.ovr, res_a.code};
            `REG_SAMPLE_B: rdata_d = {16'h0, 2'h0, mode_b, 1'b0, res_b.ovr, res_b.code};
            `REG_COUNT: rdata_d = count_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // one wait state: ack one cycle after the request, dropped the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_q <= cyc_i && stb_i && !ack_q;
            dat_o <= rd ? rdata_d : 32'h0000_0000;
        end
    end

    assign ack_o = ack_q;
endmodule // adc_port_top
`default_nettype wire

// ===== sim/capture_model.sv
// capturing logic that latches both result buses on the falling data-ready edge
`timescale 1ns/1ps
`default_nettype none
module capture_model (
    // port from the converter
    input wire logic data_ready_clock_i,
    input wire adc_port_pkg::result_bus_t bus_a_i,
    input wire adc_port_pkg::result_bus_t bus_b_i,
    // captured words
    output logic [9:0] cap_a_o,
    output logic [9:0] cap_b_o
);
    import adc_port_pkg::*;
    logic [9:0] pin_a, pin_b;
    // a released bus reads back inverted, so a missing enable shows up
    assign pin_a = bus_a_i.data ^ bus_a_i.oen_n;
    assign pin_b = bus_b_i.data ^ bus_b_i.oen_n;
    // falling edge leaves half a period for the bus to settle
    always @(negedge data_ready_clock_i) begin
        cap_a_o <= pin_a;
        cap_b_o <= pin_b;
    end
endmodule // capture_model
`default_nettype wire

// ===== sim/adc_port_assertions.sv
// concurrent checks on the converter output port
`timescale 1ns/1ps
`default_nettype none
module adc_port_assertions (
    // watched ports
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic sample_clock_chan_b_i,
    input wire adc_port_pkg::result_bus_t result_bus_a_o,
    input wire adc_port_pkg::result_bus_t result_bus_b_o,
    input wire logic data_ready_clock_o,
    input wire logic stabilizer_on_o
);
    import adc_port_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic dcs_q;
    logic oen_a_q;
    sequence take_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence ctrl_wr_s;
        take_s ##1 (ack_o && we_i && adr_i[5:2] == 4'h0 && sel_i[0]);
    endsequence
    // stabilizer is on for the two middle format codes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dcs_q <= 1'h0;
        end else if (ack_o && we_i && adr_i[5:2] == 4'h0 && sel_i[0]) begin
            dcs_q <= ^dat_i[6:5];
        end
    end
    // bus a enable comes from whichever channel the swap bit routes there
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oen_a_q <= 1'h1;
        end else if (ack_o && we_i && adr_i[5:2] == 4'h0 && sel_i[0]) begin
            oen_a_q <= dat_i[0] ? (dat_i[1] || dat_i[2]) : (dat_i[3] || dat_i[4]);
        end
    end
    a_oen_follows_ctrl: assert property (ctrl_wr_s |-> ##1
        result_bus_a_o.oen_n == {10{oen_a_q}}) else $error("bus a enable does not follow control");
    a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_ack_answer: assert property (take_s |=> ack_o) else $error("request not acked");
    a_ack_unasked: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("stray ack");
    a_unmapped_zero: assert property (take_s ##0 (!we_i && adr_i[5:2] == 4'hF) |=>
        dat_o == 32'h0) else $error("unmapped read not zero");
    a_dcs_follows_fmt: assert property (ctrl_wr_s |-> ##[1:2] stabilizer_on_o == dcs_q)
        else $error("stabilizer does not follow format");
    a_oen_whole_a: assert property (result_bus_a_o.oen_n == 10'h000 ||
        result_bus_a_o.oen_n == 10'h3FF) else $error("bus a partly driven");
    a_oen_whole_b: assert property (result_bus_b_o.oen_n == 10'h000 ||
        result_bus_b_o.oen_n == 10'h3FF) else $error("bus b partly driven");
    a_ready_rise: assert property ($rose(sample_clock_chan_b_i) |->
        ##[2:4] $rose(data_ready_clock_o)) else $error("data ready missed rise");
    a_ready_fall: assert property ($fell(sample_clock_chan_b_i) |->
        ##[2:4] $fell(data_ready_clock_o)) else $error("data ready missed fall");
endmodule // adc_port_assertions
bind adc_port_top adc_port_assertions chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .sample_clock_chan_b_i, .result_bus_a_o,
    .result_bus_b_o, .data_ready_clock_o, .stabilizer_on_o);
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the converter output port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import adc_port_pkg::*;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc = 1'h0, stb = 1'h0, we = 1'h0, sclk = 1'h0;
    logic ack, irq, drdy, flag, dcs;
    logic [5:0] adr = 6'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q, cnt;
    logic [9:0] cap_a, cap_b;
    sample_t ana_a = '0, ana_b = '0;
    result_bus_t bus_a, bus_b;
    int err_total = 0, check_count = 0;
    always #5 clk_i = ~clk_i;
    // sample clock off the system grid so edges never coincide
    initial begin
        #3.3;
        forever #62.5 sclk = ~sclk;
    end
    adc_port_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .irq_o(irq),
        .sample_clock_chan_a_i(sclk), .sample_clock_chan_b_i(sclk),
        .analog_a_i(ana_a), .analog_b_i(ana_b), .result_bus_a_o(bus_a),
        .result_bus_b_o(bus_b), .data_ready_clock_o(drdy), .range_exceeded_flag_o(flag),
        .stabilizer_on_o(dcs));
    capture_model cap_u (.data_ready_clock_i(drdy), .bus_a_i(bus_a), .bus_b_i(bus_b),
        .cap_a_o(cap_a), .cap_b_o(cap_b));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 20);
        chk("ack", 32'h1, {31'h0, ack});
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge sclk);
        repeat (8) @(posedge clk_i);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200us;
        err_total++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(0, 6'h00, 32'h0);
        chk("ctrl reset", 32'h15, q);
        chk("oen reset", 32'h3FF, {22'h0, bus_a.oen_n});
        chk("oen b reset", 32'h3FF, {22'h0, bus_b.oen_n});
        wb(0, 6'h3C, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("test reset done");
        ana_a <= {1'h0, 10'h155};
        ana_b <= {1'h0, 10'h2A3};
        wb(1, 6'h00, 32'h01);
        settle(7);
        chk("bus a", 32'h155, {22'h0, bus_a.data});
        chk("bus b", 32'h2A3, {22'h0, bus_b.data});
        chk("oen a", 32'h0, {22'h0, bus_a.oen_n});
        chk("capture", 32'h155, {22'h0, cap_a});
        chk("capture b", 32'h2A3, {22'h0, cap_b});
        chk("oen b", 32'h0, {22'h0, bus_b.oen_n});
        wb(1, 6'h00, 32'h00);
        settle(7);
        chk("swap a", 32'h2A3, {22'h0, bus_a.data});
        chk("swap b", 32'h155, {22'h0, bus_b.data});
        $display("test routing done");
        for (int f = 0; f < 4; f++) begin
            wb(1, 6'h00, {25'h0, 2'(f), 5'h01});
            settle(7);
            chk("format", {22'h0, 10'h155 ^ (f > 1 ? 10'h200 : 10'h0)}, bus_a.data);
            chk("stabilizer", {31'h0, f == 1 || f == 2}, {31'h0, dcs});
        end
        for (int m = 0; m < 4; m++) begin
            wb(1, 6'h00, {29'h0, m[0], m[1], 1'h1});
            settle(2);
            chk("mode oen", (m == 0) ? 32'h0 : 32'h3FF, {22'h0, bus_a.oen_n});
            wb(0, 6'h10, 32'h0);
            chk("mode", 32'(m), {30'h0, q[13:12]});
        end
        $display("test modes done");
        wb(1, 6'h00, 32'h01);
        wb(1, 6'h0C, 32'h1);
        settle(7);
        @(negedge sclk);
        @(posedge clk_i);
        ana_a <= {1'h1, 10'h3FF};
        settle(4);
        chk("early data", 32'h155, {22'h0, bus_a.data});
        chk("early flag", 32'h0, {31'h0, flag});
        settle(1);
        chk("late data", 32'h3FF, {22'h0, bus_a.data});
        chk("late flag", 32'h1, {31'h0, flag});
        // the event is raised as the overflowed sample leaves, one take later
        settle(1);
        chk("irq set", 32'h1, {31'h0, irq});
        wb(0, 6'h04, 32'h0);
        chk("status", 32'h5, q);
        wb(1, 6'h0C, 32'h0);
        repeat (2) @(posedge clk_i);
        chk("irq masked", 32'h0, {31'h0, irq});
        ana_a <= {1'h0, 10'h155};
        ana_b <= {1'h1, 10'h2A3};
        settle(7);
        chk("flag b", 32'h1, {31'h0, flag});
        ana_b <= {1'h0, 10'h2A3};
        settle(7);
        chk("flag clear", 32'h0, {31'h0, flag});
        wb(1, 6'h08, 32'h7);
        wb(1, 6'h0C, 32'h3);
        repeat (2) @(posedge clk_i);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wb(0, 6'h04, 32'h0);
        chk("status cleared", 32'h0, {30'h0, q[1:0]});
        wb(0, 6'h0C, 32'h0);
        chk("irq enable", 32'h3, q);
        $display("test overflow done");
        wb(1, 6'h00, 32'h09);
        settle(1);
        wb(0, 6'h18, 32'h0);
        cnt = q;
        settle(3);
        wb(0, 6'h18, 32'h0);
        chk("count held", cnt, q);
        wb(0, 6'h14, 32'h0);
        chk("mode b", 32'h2, {30'h0, q[13:12]});
        wb(1, 6'h00, 32'h01);
        settle(1);
        wb(0, 6'h18, 32'h0);
        cnt = q;
        settle(3);
        wb(0, 6'h18, 32'h0);
        chk("count run", cnt + 32'h3, q);
        $display("test sampling done");
        final_report();
    end
endmodule // testbench
`default_nettype wire
